/* pkg/wdrt_pkg.sv */
// Package with register map, field layout, reset values and timing counts of the watchdog reset timer.
package wdrt_pkg;

    // Byte addresses of the registers on the host register port.
    localparam logic [15:0] WDRT_CTRL_ADDR      = 16'h3000;
    localparam logic [15:0] WDRT_CTRL_HI_ADDR   = 16'h3001;
    localparam logic [15:0] WDRT_KICK_ADDR      = 16'h3002;
    localparam logic [15:0] WDRT_COUNT_ADDR     = 16'h3004;
    localparam logic [15:0] WDRT_LOAD_ADDR      = 16'h3008;
    localparam logic [15:0] WDRT_RSVD_LO_ADDR   = 16'h300C;
    localparam logic [15:0] WDRT_RSVD_HI_ADDR   = 16'h33FF;

    // Bit positions inside the control register.
    localparam int WDRT_CTRL_EN_BIT   = 0;
    localparam int WDRT_CTRL_STS_BIT  = 1;
    localparam int WDRT_CTRL_SIM_BIT  = 2;
    localparam int WDRT_CTRL_UNIT_BIT = 3;

    // Reset values.
    localparam logic        WDRT_EN_RST    = 1'b0;
    localparam logic        WDRT_SIM_RST   = 1'b0;
    localparam logic        WDRT_UNIT_RST  = 1'b0;
    localparam logic [31:0] WDRT_LOAD_RST  = 32'hFFFF_FFFF;
    localparam logic [31:0] WDRT_COUNT_RST = 32'hFFFF_FFFF;
    localparam logic [7:0]  WDRT_KICK_READ = 8'h00;

    // Timing: system clock period and tick periods.
    localparam int WDRT_CLK_PERIOD_NS = 8;
    localparam int WDRT_MS_TICK_NS    = 1000000;
    localparam int WDRT_US_TICK_NS    = 1000;
    localparam int WDRT_SIM_TICK_NS   = 1000;
    localparam int WDRT_MS_TICK_CYC   = WDRT_MS_TICK_NS / WDRT_CLK_PERIOD_NS;
    localparam int WDRT_US_TICK_CYC   = WDRT_US_TICK_NS / WDRT_CLK_PERIOD_NS;
    localparam int WDRT_SIM_TICK_CYC  = WDRT_SIM_TICK_NS / WDRT_CLK_PERIOD_NS;

    // Length of the system reset request pulse.
    localparam int WDRT_RST_PULSE_NS  = 128;
    localparam int WDRT_RST_PULSE_CYC = WDRT_RST_PULSE_NS / WDRT_CLK_PERIOD_NS;

    localparam int WDRT_DIV_W = 17;
    localparam int WDRT_RST_W = 5;

endpackage

/* core/wdrt_tick_gen.sv */
// Tick divider that stands in for the slow, fast and simulation counter clocks.
`timescale 1ns/1ps
module wdrt_tick_gen
    import wdrt_pkg::*;
#(
    parameter int MS_TICK_CYC = WDRT_MS_TICK_CYC
) (
    input  wire logic sys_clk_i,   // System clock.
    input  wire logic reset_i,     // Synchronous reset, active high.
    input  wire logic run_i,       // Divider runs only while high.
    input  wire logic unit_us_i,   // High selects 1 us ticks.
    input  wire logic sim_i,       // High selects the 1 MHz simulation tick.
    output logic      tick_o       // One-cycle counter clock enable.
);

    typedef struct packed {
        logic [WDRT_DIV_W-1:0] div;
        logic                  tick;
    } wdrt_tick_st_t;

    wdrt_tick_st_t st_ff;
    wdrt_tick_st_t nxt_st;
    logic [WDRT_DIV_W-1:0] period;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (sim_i) begin                                                       // [R12]
            period = WDRT_DIV_W'(WDRT_SIM_TICK_CYC - 1);
        end else if (unit_us_i) begin                                          // [R2] [R3]
            period = WDRT_DIV_W'(WDRT_US_TICK_CYC - 1);
        end else begin
            period = WDRT_DIV_W'(MS_TICK_CYC - 1);
        end
        // A stopped divider draws no toggling power, like a gated oscillator.
        if (reset_i || !run_i) begin                                           // [R6]
            nxt_st.div = '0;
        end else if (st_ff.div >= period) begin
            nxt_st.div  = '0;
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.div = st_ff.div + WDRT_DIV_W'(1);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        st_ff <= nxt_st;
    end

    assign tick_o = st_ff.tick;

endmodule

/* core/wdrt_watchdog.sv */
// Watchdog reset timer with its host register port, counter and reset request.
`timescale 1ns/1ps
// How it works
// (R1) While enabled, counter underflow without reload requests a system reset.
// (R2) Counter ticks come from slow or fast clock per tick-unit bit.
// (R3) Tick-unit bit 3: 0 gives 1 ms ticks, 1 gives 1 us; resets 0.
// (R4) Reset-event flag mirrors the underflow status and clears only with it.
// (R5) Software disables, writes load value, then enables to start counting.
// (R6) Clearing enable stops the counter and gates its tick clock.
// (R7) Underflow both requests reset and sets the underflow status bit.
// (R8) Software reloads in time by reactivating or writing the kick register.
// (R9) Interval is the time from the load value down to zero.
// (R10) While status is pending, host writes are blocked until status clears.
// (R11) Software never writes the reserved range after the watchdog registers.
// (R12) Simulation bit 2 runs the counter at 1 MHz; software sets units too.
// (R13) Status bit 1 set by hardware, write 1 clears, write 0 ignored.
// (R14) After reset, status reads 1 only if a watchdog underflow caused it.
// (R15) Enable bit 0 resets 0; counting starts a few ticks after setting.
// (R16) Any kick write reloads and resumes counting while enabled; else ignored.
// (R17) Kick reload is synchronised to the counter tick, so it lags.
// (R18) Kick register always reads zero.
// (R19) Load accepts writes only while disabled; resets all ones; never zero.
// (R20) Reading count byte 0 snapshots the counter; upper bytes read afterwards.
// (R21) Reset request is a registered pulse long enough to capture reliably.
module wdrt_watchdog
    import wdrt_pkg::*;
#(
    parameter int MS_TICK_CYC = WDRT_MS_TICK_CYC
) (
    input  wire logic        sys_clk_i,        // System clock, 125 MHz.
    input  wire logic        reset_i,          // Device reset, synchronous, active high.
    input  wire logic        cold_reset_i,     // Power-on reset, also clears the status bit.
    input  wire logic [15:0] reg_addr_i,       // Byte address from the host port.
    input  wire logic        reg_wr_i,         // Byte write strobe.
    input  wire logic [7:0]  reg_wdata_i,      // Write data byte.
    input  wire logic        reg_rd_i,         // Byte read strobe.
    output logic [7:0]       reg_rdata_o,      // Read data, valid the cycle after reg_rd_i.
    output logic             write_block_o,    // Host port must refuse writes.
    output logic             reset_event_irq_flag_o, // Watchdog reset flag for the interrupt enable register.
    output logic             wdt_reset_o       // System reset request pulse.
);

    typedef struct packed {
        logic                  counter_enable;
        logic                  fast_sim_select;
        logic                  tick_unit_select;
        logic                  underflow_reset_flag;
        logic [31:0]           load;
        logic [31:0]           count;
        logic [31:0]           snap;
        logic                  run_sync;
        logic                  kick_pend;
        logic [7:0]            rdata;
        logic [WDRT_RST_W-1:0] rst_cnt;
    } wdrt_st_t;

    wdrt_st_t st_ff;
    wdrt_st_t nxt_st;
    logic     tick;
    logic     wr_ok;
    logic     underflow;

    // Byte lane of a 32-bit register selected by the low address bits.
    function automatic logic [7:0] wdrt_byte(input logic [31:0] word, input logic [1:0] lane);
        return word[lane*8 +: 8];
    endfunction

    function automatic logic wdrt_in_word(input logic [15:0] addr, input logic [15:0] base);
        return addr[15:2] == base[15:2];
    endfunction

    wdrt_tick_gen #(
        .MS_TICK_CYC (MS_TICK_CYC)
    ) u_tick (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i || cold_reset_i),
        .run_i     (st_ff.counter_enable),
        .unit_us_i (st_ff.tick_unit_select),
        .sim_i     (st_ff.fast_sim_select),
        .tick_o    (tick)
    );

    // Writes are refused while a watchdog event is pending, except the one
    // control write that clears it; otherwise software could never recover.
    assign wr_ok = reg_wr_i && (!st_ff.underflow_reset_flag                  // [R10]
                   || (reg_addr_i == WDRT_CTRL_ADDR));
    // A tick registered on the edge that clears enable must not underflow afterwards.
    assign underflow = tick && st_ff.counter_enable && st_ff.run_sync && !st_ff.kick_pend    // [R6]
                       && (st_ff.count <= 32'h0000_0001);                      // [R9]

    always_comb begin
        nxt_st = st_ff;

        // Counter side, advanced only on tick enables.
        if (!st_ff.counter_enable) begin
            nxt_st.run_sync  = 1'b0;                                           // [R6]
            nxt_st.kick_pend = 1'b0;
        end else if (tick) begin
            nxt_st.run_sync  = 1'b1;                                           // [R15]
            nxt_st.kick_pend = 1'b0;
            if (!st_ff.run_sync || st_ff.kick_pend) begin
                nxt_st.count = st_ff.load;                                     // [R16] [R17]
            end else if (underflow) begin
                nxt_st.count = st_ff.load;
            end else begin
                nxt_st.count = st_ff.count - 32'h0000_0001;                    // [R9]
            end
        end

        if (underflow) begin
            nxt_st.underflow_reset_flag = 1'b1;                                // [R7]
            nxt_st.rst_cnt = WDRT_RST_W'(WDRT_RST_PULSE_CYC);                  // [R1] [R21]
        end else if (st_ff.rst_cnt != '0) begin
            nxt_st.rst_cnt = st_ff.rst_cnt - WDRT_RST_W'(1);
        end

        // Host writes.
        if (wr_ok) begin
            if (reg_addr_i == WDRT_CTRL_ADDR) begin
                if (!st_ff.underflow_reset_flag) begin
                    nxt_st.counter_enable   = reg_wdata_i[WDRT_CTRL_EN_BIT];   // [R15]
                    nxt_st.fast_sim_select  = reg_wdata_i[WDRT_CTRL_SIM_BIT];  // [R12]
                    nxt_st.tick_unit_select = reg_wdata_i[WDRT_CTRL_UNIT_BIT]; // [R3]
                end
                if (reg_wdata_i[WDRT_CTRL_STS_BIT] && !underflow) begin
                    nxt_st.underflow_reset_flag = 1'b0;                        // [R13]
                end
            end else if (reg_addr_i == WDRT_KICK_ADDR) begin
                if (st_ff.counter_enable) begin
                    nxt_st.kick_pend = 1'b1;                                   // [R16] [R17]
                end
            end else if (wdrt_in_word(reg_addr_i, WDRT_LOAD_ADDR)) begin
                if (!st_ff.counter_enable) begin
                    nxt_st.load[reg_addr_i[1:0]*8 +: 8] = reg_wdata_i;         // [R19]
                end
            end
        end

        // Host reads, one cycle of latency.
        nxt_st.rdata = 8'h00;
        if (reg_rd_i) begin
            if (reg_addr_i == WDRT_CTRL_ADDR) begin
                nxt_st.rdata = 8'h00;
                nxt_st.rdata[WDRT_CTRL_EN_BIT]   = st_ff.counter_enable;
                nxt_st.rdata[WDRT_CTRL_STS_BIT]  = st_ff.underflow_reset_flag;
                nxt_st.rdata[WDRT_CTRL_SIM_BIT]  = st_ff.fast_sim_select;
                nxt_st.rdata[WDRT_CTRL_UNIT_BIT] = st_ff.tick_unit_select;
            end else if (reg_addr_i == WDRT_KICK_ADDR) begin
                nxt_st.rdata = WDRT_KICK_READ;                                 // [R18]
            end else if (reg_addr_i == WDRT_COUNT_ADDR) begin
                nxt_st.snap  = st_ff.count;                                    // [R20]
                nxt_st.rdata = wdrt_byte(st_ff.count, 2'b00);
            end else if (wdrt_in_word(reg_addr_i, WDRT_COUNT_ADDR)) begin
                nxt_st.rdata = wdrt_byte(st_ff.snap, reg_addr_i[1:0]);         // [R20]
            end else if (wdrt_in_word(reg_addr_i, WDRT_LOAD_ADDR)) begin
                nxt_st.rdata = wdrt_byte(st_ff.load, reg_addr_i[1:0]);
            end
        end

        // The status bit survives a device reset so that software can see
        // afterwards whether the watchdog caused it; of the two resets only power-on clears it.
        if (reset_i || cold_reset_i) begin
            nxt_st.counter_enable   = WDRT_EN_RST;
            nxt_st.fast_sim_select  = WDRT_SIM_RST;
            nxt_st.tick_unit_select = WDRT_UNIT_RST;                           // [R3]
            nxt_st.load      = WDRT_LOAD_RST;                                  // [R19]
            nxt_st.count     = WDRT_COUNT_RST;
            nxt_st.snap      = WDRT_COUNT_RST;
            nxt_st.run_sync  = 1'b0;
            nxt_st.kick_pend = 1'b0;
            nxt_st.rdata     = 8'h00;
            nxt_st.rst_cnt   = '0;
            nxt_st.underflow_reset_flag = cold_reset_i ? 1'b0
                                          : st_ff.underflow_reset_flag;        // [R14]
        end
    end

    always_ff @(posedge sys_clk_i) begin
        st_ff <= nxt_st;
    end

    assign reg_rdata_o            = st_ff.rdata;
    assign write_block_o          = st_ff.underflow_reset_flag;                // [R10]
    assign reset_event_irq_flag_o = st_ff.underflow_reset_flag;                // [R4]
    assign wdt_reset_o            = st_ff.rst_cnt != '0;                       // [R21]

endmodule

/* sim/wdrt_watchdog_assertions.sv */
// Port-level checker of the watchdog reset timer, bound to its top module.
`timescale 1ns/1ps
module wdrt_watchdog_checker
    import wdrt_pkg::*;
(
    input wire logic        sys_clk_i,              // System clock.
    input wire logic        reset_i,                // Device reset.
    input wire logic        cold_reset_i,           // Power-on reset.
    input wire logic [15:0] reg_addr_i,             // Byte address.
    input wire logic        reg_wr_i,               // Write strobe.
    input wire logic [7:0]  reg_wdata_i,            // Write data.
    input wire logic        reg_rd_i,               // Read strobe.
    input wire logic [7:0]  reg_rdata_o,            // Read data.
    input wire logic        write_block_o,          // Write refusal.
    input wire logic        reset_event_irq_flag_o, // Reset flag.
    input wire logic        wdt_reset_o             // Reset request.
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i || cold_reset_i);
    logic clr_wr;
    assign clr_wr = reg_wr_i && reg_addr_i == WDRT_CTRL_ADDR && reg_wdata_i[WDRT_CTRL_STS_BIT];
    property p_pulse_len;
        $rose(wdt_reset_o) |-> wdt_reset_o [*8] ##1 wdt_reset_o [*8] ##1 !wdt_reset_o;
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("reset pulse length wrong");
    property p_sts_on_rst;
        $rose(wdt_reset_o) |-> write_block_o && reset_event_irq_flag_o;
    endproperty
    a_sts_on_rst: assert property (p_sts_on_rst) else $error("status not set with reset");
    property p_flag_rise;
        $rose(reset_event_irq_flag_o) |-> $rose(wdt_reset_o);
    endproperty
    a_flag_rise: assert property (p_flag_rise) else $error("flag rose without reset");
    property p_flag_eq;
        reset_event_irq_flag_o == write_block_o;
    endproperty
    a_flag_eq: assert property (p_flag_eq) else $error("flag and write block differ");
    property p_kick_rd;
        reg_rd_i && reg_addr_i == WDRT_KICK_ADDR |=> reg_rdata_o == WDRT_KICK_READ;
    endproperty
    a_kick_rd: assert property (p_kick_rd) else $error("kick read not zero");
    property p_sts_rd;
        reg_rd_i && reg_addr_i == WDRT_CTRL_ADDR |=> reg_rdata_o[1] == $past(reset_event_irq_flag_o);
    endproperty
    a_sts_rd: assert property (p_sts_rd) else $error("status read differs from flag");
    property p_clear;
        clr_wr |=> !reset_event_irq_flag_o || $rose(wdt_reset_o);
    endproperty
    a_clear: assert property (p_clear) else $error("status not cleared by write");
    property p_hold;
        reset_event_irq_flag_o && !clr_wr |=> reset_event_irq_flag_o;
    endproperty
    a_hold: assert property (p_hold) else $error("flag dropped without clear");
endmodule
bind wdrt_watchdog wdrt_watchdog_checker u_checker (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .cold_reset_i(cold_reset_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .write_block_o(write_block_o),
    .reset_event_irq_flag_o(reset_event_irq_flag_o), .wdt_reset_o(wdt_reset_o));

/* sim/wdrt_host_model.sv */
// Host software model that reaches the watchdog registers byte by byte.
`timescale 1ns/1ps
module wdrt_host_model
    import wdrt_pkg::*;
(
    input  wire logic       sys_clk_i,   // System clock.
    input  wire logic [7:0] reg_rdata_i, // Read data from the device.
    output logic [15:0]     reg_addr_o,  // Byte address.
    output logic            reg_wr_o,    // Write strobe.
    output logic [7:0]      reg_wdata_o, // Write data.
    output logic            reg_rd_o     // Read strobe.
);
    initial begin
        reg_addr_o = 16'h0000;
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'h00;
        reg_rd_o = 1'b0;
    end
    // Callers never pass an address of the reserved range to this task.
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_o <= 1'b0;
        reg_wdata_o <= ~d;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_o <= a;
        reg_rd_o <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_o <= 1'b0;
        // The answer stands for the cycle after the strobe; take it at the edge that closes that cycle.
        @(posedge sys_clk_i);
        d = reg_rdata_i;
    endtask
    // Disable, program the load value, then enable; a zero load is never passed.
    task automatic start(input logic [31:0] ld, input logic [7:0] ctl);
        wr(WDRT_CTRL_ADDR, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(WDRT_LOAD_ADDR + 16'(i), ld[8*i +: 8]);
        end
        wr(WDRT_CTRL_ADDR, ctl);
    endtask
    task automatic kick();
        wr(WDRT_KICK_ADDR, 8'h5A);
    endtask
    // The low byte goes first so the upper bytes come from the same snapshot.
    task automatic rd_count(output logic [31:0] c);
        for (int i = 0; i < 4; i++) begin
            rd(WDRT_COUNT_ADDR + 16'(i), c[8*i +: 8]);
        end
    endtask
endmodule

/* sim/watchdog_reset_timer_tb_top.sv */
// Self-checking testbench of the watchdog reset timer.
`timescale 1ns/1ps
module watchdog_reset_timer_tb_top import wdrt_pkg::*;;
    localparam int TC = 10;
    localparam int TU = 125;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic cold_reset_i = 1'b1;
    logic [15:0] addr;
    logic wr, rd, wblk, flag, wrst;
    logic [7:0] wdata, rdata, d;
    logic [31:0] cnt;
    int fail_count = 0;
    int compares = 0;
    always #4 sys_clk_i = ~sys_clk_i;
    wdrt_watchdog #(.MS_TICK_CYC(TC)) DUT (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .cold_reset_i(cold_reset_i),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .write_block_o(wblk), .reset_event_irq_flag_o(flag), .wdt_reset_o(wrst));
    wdrt_host_model u_host (.sys_clk_i(sys_clk_i), .reg_rdata_i(rdata), .reg_addr_o(addr), .reg_wr_o(wr),
        .reg_wdata_o(wdata), .reg_rd_o(rd));
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic chk_bit(input logic e, input logic g);
        chk8({7'h00, e}, {7'h00, g});
    endtask
    task automatic rdc(input logic [15:0] a, input logic [7:0] e);
        u_host.rd(a, d);
        chk8(e, d);
    endtask
    task automatic quiet(input int n);
        repeat (n) @(posedge sys_clk_i) chk_bit(1'b0, wrst);
    endtask
    // The TU windows are tight on purpose: a count off by one tick falls outside them, unlike the TC window.
    task automatic wait_rst(input int lo, input int hi);
        int n;
        n = 0;
        while (wrst !== 1'b1 && n < hi) begin
            @(posedge sys_clk_i);
            n++;
        end
        chk_bit(1'b1, n >= lo && n < hi);
        if (n >= hi) give_verdict();
    endtask
    initial begin
        repeat (20) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        cold_reset_i <= 1'b0;
        rdc(WDRT_CTRL_ADDR, 8'h00);
        rdc(WDRT_KICK_ADDR, 8'h00);
        rdc(WDRT_LOAD_ADDR + 16'h0003, 8'hFF);
        u_host.rd_count(cnt);
        chk8(8'hFF, cnt[31:24]);
        rdc(WDRT_RSVD_LO_ADDR, 8'h00);
        $display("test reset_values done");
        u_host.start(32'h0000_0005, 8'h01);
        quiet(25);
        u_host.rd_count(cnt);
        chk8(8'h00, cnt[31:24]);
        chk_bit(1'b1, cnt[7:0] <= 8'h05 && cnt[7:0] != 8'h00);
        u_host.wr(WDRT_LOAD_ADDR, 8'h09);
        rdc(WDRT_LOAD_ADDR, 8'h05);
        repeat (3) begin
            u_host.kick();
            quiet(40);
        end
        // The interval window is timed from a fresh kick, not from the end of a quiet stretch.
        u_host.kick();
        wait_rst(5 * TC, 6 * TC + 6);
        chk_bit(1'b1, wblk);
        chk_bit(1'b1, flag);
        rdc(WDRT_CTRL_ADDR, 8'h03);
        u_host.wr(WDRT_CTRL_ADDR, 8'h08);
        rdc(WDRT_CTRL_ADDR, 8'h03);
        u_host.wr(WDRT_CTRL_ADDR, 8'h02);
        rdc(WDRT_CTRL_ADDR, 8'h01);
        chk_bit(1'b0, flag);
        chk_bit(1'b0, wblk);
        u_host.wr(WDRT_CTRL_ADDR, 8'h00);
        quiet(200);
        u_host.kick();
        quiet(100);
        $display("test kick_and_block done");
        u_host.start(32'h0000_0002, 8'h0D);
        wait_rst(3 * TU - 3, 3 * TU + 6);
        reset_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        rdc(WDRT_CTRL_ADDR, 8'h02);
        rdc(WDRT_LOAD_ADDR, 8'hFF);
        cold_reset_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        cold_reset_i <= 1'b0;
        rdc(WDRT_CTRL_ADDR, 8'h00);
        u_host.start(32'h0000_0002, 8'h09);
        wait_rst(3 * TU - 3, 3 * TU + 6);
        $display("test fast_ticks_and_reset done");
        give_verdict();
    end
endmodule
